//--- verilog/hsl_pkg.sv
// Shared constants for the serial link pins and receive signalling block
package hsl_pkg;
	localparam int HSL_CLK_HZ = 125000000;
	localparam logic [7:0] HSL_OCTET_LAST = 8'h07;
	localparam logic [2:0] HSL_BIT_ZERO = 3'h0;
	localparam logic [2:0] HSL_BIT_LAST = 3'h7;
	localparam logic [2:0] HSL_Q_DEPTH = 3'h6;
	localparam logic [2:0] HSL_Q_ZERO = 3'h0;
	localparam logic [2:0] HSL_Q_ONE = 3'h1;
	localparam logic [7:0] HSL_FLAG = 8'h7E;
	localparam logic [7:0] HSL_BYTE_ZERO = 8'h00;
	localparam logic [7:0] HSL_SR_RESET = 8'h00;
	localparam logic [1:0] HSL_SYNC_IDLE = 2'h0;
	localparam int HSL_BUF_DEPTH = 2;
	localparam int HSL_BUF_IDX_W = 1;
endpackage

//--- verilog/hsl_skid_buf.sv
// Two-entry valid/ready buffer for received octets
`timescale 1ns/1ps
module hsl_skid_buf
	import hsl_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	output logic [7:0] o_data,
	output logic o_valid,
	input wire logic i_ready
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [HSL_BUF_DEPTH-1:0][7:0] mem; // Storage entries
		logic [HSL_BUF_IDX_W-1:0] wr; // Write index
		logic [HSL_BUF_IDX_W-1:0] rd; // Read index
		logic [1:0] cnt; // Occupancy
	} hsl_buf_t;
	hsl_buf_t st;
	hsl_buf_t next_st;
	logic push;
	logic pop;

	// Handshake terms
	assign push = i_valid && (st.cnt != 2'h2);
	assign pop = i_ready && (st.cnt != 2'h0);
	assign o_ready = (st.cnt != 2'h2);
	assign o_valid = (st.cnt != 2'h0);
	assign o_data = st.mem[st.rd];

	// Next state
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = i_data;
			next_st.wr = st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = st.rd + 1'b1;
		end
		next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
	end

	// Register
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

//--- verilog/hsl_link.sv
// Serial link pins, receive queue and receive signalling
`timescale 1ns/1ps
// Functional notes
// - Level-one control enables clear-to-send handshake
// - Level-one control drives request-to-send output
// - Transmit bit changes on falling edge
// - Transmit octet least significant bit first
// - Invert bit inverts transmit and receive
// - First received bit is byte bit 0
// - Receive data sampled on rising edge
// - End of frame raises end-of-frame interrupt
// - End-of-frame interrupt gated by enable bit
// - End-of-frame polarity bit sets active level
// - DMA/interrupt polarity bit sets active level
// - Interrupt mode: count at least fill level
// - Data available never with transmit request
// - Acknowledge with data available drives byte
module hsl_link
	import hsl_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_level_one_control_bit,
	input wire logic i_serial_invert_bit,
	input wire logic i_end_of_frame_enable_bit,
	input wire logic i_end_of_frame_polarity_bit,
	input wire logic i_dma_irq_polarity_bit,
	input wire logic i_dma_select_bit,
	input wire logic i_rx_irq_dma_disable_bit,
	input wire logic [2:0] i_rx_fill_level,
	input wire logic i_tx_request_bit,
	input wire logic [7:0] i_tx_octet,
	input wire logic i_tx_octet_valid,
	output logic o_tx_octet_ready,
	input wire logic i_tx_data_request,
	input wire logic i_tx_serial_clock,
	input wire logic i_rx_serial_clock,
	input wire logic i_rx_data,
	input wire logic i_clear_to_send_b,
	output logic o_tx_data,
	output logic o_tx_data_oe,
	output logic o_request_to_send_b,
	output logic o_request_to_send_oe,
	output logic o_rx_end_of_frame_irq,
	output logic o_rx_end_of_frame_irq_oe,
	output logic o_rx_irq_or_data_avail,
	output logic o_rx_irq_or_data_avail_oe,
	input wire logic i_dma_acknowledge,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic [2:0] o_rx_count
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] tck_s; // Transmit clock synchroniser
		logic [2:0] rck_s; // Receive clock synchroniser
		logic [2:0] rxd_s; // Receive data synchroniser
		logic [2:0] cts_s; // Clear-to-send synchroniser
		logic tck_q; // Agreed transmit clock level
		logic rck_q; // Agreed receive clock level
		logic [7:0] tx_sr; // Transmit shift register
		logic [2:0] tx_bit; // Transmit bit index
		logic tx_busy; // Octet in flight
		logic tx_ready; // Octet port ready, kept as a flop
		logic txd; // Transmit pin level
		logic rts_b; // Request-to-send pin level
		logic [7:0] rx_sr; // Receive shift register
		logic [2:0] rx_bit; // Receive bit count
		logic [7:0] flag_sr; // Flag hunter
		logic in_frame; // Octets seen since opening flag
		logic eof; // End-of-frame event pending
		logic [HSL_Q_DEPTH-1:0][7:0] q; // Receive queue
		logic [2:0] q_cnt; // Queue occupancy
		logic dav; // Data available request latch
		logic eof_pin; // End-of-frame pin level
		logic eof_oe; // End-of-frame pin enable
		logic rx_pin; // Receive signal pin level
		logic rx_oe; // Receive signal pin enable
		logic [7:0] dout; // Data bus level
		logic dout_oe; // Data bus enable
		logic ack_q; // Acknowledge previous sample
	} hsl_st_t;
	hsl_st_t st;
	hsl_st_t next_st;
	logic [7:0] buf_data;
	logic buf_valid;
	logic buf_ready;
	logic rx_push;
	logic [7:0] rx_byte;
	logic ack_rise;
	logic rx_active;

	// ------------------------------------------------------------
	// Receive octet buffer in front of the queue
	// ------------------------------------------------------------
	hsl_skid_buf u_buf (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_data(rx_byte),
		.i_valid(rx_push),
		.o_ready(),
		.o_data(buf_data),
		.o_valid(buf_valid),
		.i_ready(buf_ready)
	);

	assign buf_ready = (st.q_cnt != HSL_Q_DEPTH) && !ack_rise;
	assign ack_rise = i_dma_acknowledge && !st.ack_q && st.dav;
	assign o_tx_octet_ready = st.tx_ready;
	assign o_rx_count = st.q_cnt;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic rxd_in;
		logic tck_fall;
		logic rck_rise;
		logic cts_ok;
		rxd_in = 1'b0;
		tck_fall = 1'b0;
		rck_rise = 1'b0;
		cts_ok = 1'b0;
		next_st = st;
		rx_push = 1'b0;
		rx_byte = HSL_BYTE_ZERO;
		rx_active = 1'b0;
		// Synchronisers; a change counts when stages two and three agree
		next_st.tck_s = {st.tck_s[1:0], i_tx_serial_clock};
		next_st.rck_s = {st.rck_s[1:0], i_rx_serial_clock};
		next_st.rxd_s = {st.rxd_s[1:0], i_rx_data};
		next_st.cts_s = {st.cts_s[1:0], i_clear_to_send_b};
		if (st.tck_s[1] == st.tck_s[2]) begin
			next_st.tck_q = st.tck_s[2];
		end
		if (st.rck_s[1] == st.rck_s[2]) begin
			next_st.rck_q = st.rck_s[2];
		end
		tck_fall = st.tck_q && !next_st.tck_q;
		rck_rise = !st.rck_q && next_st.rck_q;
		rxd_in = st.rxd_s[2] ^ i_serial_invert_bit;
		cts_ok = !i_level_one_control_bit || !st.cts_s[2];
		next_st.rts_b = !(i_level_one_control_bit && i_tx_request_bit);
		// Load a new octet when idle
		if (!st.tx_busy && i_tx_octet_valid) begin
			next_st.tx_sr = i_tx_octet;
			next_st.tx_bit = HSL_BIT_ZERO;
			next_st.tx_busy = 1'b1;
		end
		if (tck_fall && st.tx_busy && cts_ok) begin
			next_st.txd = st.tx_sr[0] ^ i_serial_invert_bit;
			next_st.tx_sr = {1'b0, st.tx_sr[7:1]};
			next_st.tx_bit = st.tx_bit + 1'b1;
			if (st.tx_bit == HSL_BIT_LAST) begin
				next_st.tx_busy = 1'b0;
			end
		end
		// Ready mirrors the busy state it will hold next
		next_st.tx_ready = !next_st.tx_busy;
		if (rck_rise) begin
			next_st.flag_sr = {rxd_in, st.flag_sr[7:1]};
			// First bit lands in bit 0
			next_st.rx_sr = {rxd_in, st.rx_sr[7:1]};
			next_st.rx_bit = st.rx_bit + 1'b1;
			if (next_st.flag_sr == HSL_FLAG) begin
				// Closing flag marks end of frame
				if (st.in_frame) begin
					next_st.eof = 1'b1;
				end
				next_st.in_frame = 1'b0;
				next_st.rx_bit = HSL_BIT_ZERO;
			end else if (st.rx_bit == HSL_BIT_LAST) begin
				rx_push = 1'b1;
				rx_byte = next_st.rx_sr;
				next_st.in_frame = 1'b1;
			end
		end
		// Move buffered octets into the queue
		if (buf_valid && buf_ready) begin
			next_st.q[st.q_cnt] = buf_data;
		end
		// Acknowledge pops one byte onto the bus
		next_st.ack_q = i_dma_acknowledge;
		// Bus stays driven for the whole acknowledge, even when the pop empties the queue
		next_st.dout_oe = i_dma_acknowledge && (st.dav || st.dout_oe);
		if (ack_rise) begin
			next_st.dout = st.q[0];
			for (int i = 0; i < HSL_Q_DEPTH - 1; i++) begin
				next_st.q[i] = st.q[i + 1];
			end
		end
		next_st.q_cnt = st.q_cnt + {2'b00, buf_valid && buf_ready} - {2'b00, ack_rise};
		// Data available set at level, cleared on empty
		if (!i_dma_select_bit || i_rx_irq_dma_disable_bit || next_st.q_cnt == HSL_Q_ZERO) begin
			next_st.dav = 1'b0;
		end else if (next_st.q_cnt >= i_rx_fill_level) begin
			next_st.dav = 1'b1;
		end
		if (i_tx_data_request) begin
			next_st.dav = 1'b0;
		end
		if (i_dma_select_bit) begin
			rx_active = next_st.dav;
		end else begin
			rx_active = !i_rx_irq_dma_disable_bit && (next_st.q_cnt >= i_rx_fill_level);
		end
		next_st.rx_pin = i_dma_irq_polarity_bit ? rx_active : !rx_active;
		next_st.rx_oe = !next_st.rx_pin;
		// Enable gate; event held until disabled
		if (!i_end_of_frame_enable_bit) begin
			next_st.eof = 1'b0;
		end
		next_st.eof_pin = i_end_of_frame_polarity_bit ? next_st.eof : !next_st.eof;
		next_st.eof_oe = !next_st.eof_pin;
	end

	// ------------------------------------------------------------
	// Register
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
			st.rts_b <= 1'b1;
			st.eof_pin <= 1'b1;
			st.rx_pin <= 1'b1;
			st.txd <= 1'b1;
			st.tx_ready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state flops, except the transmit and request-to-send enables, which are tied high
	assign o_tx_data = st.txd;
	assign o_tx_data_oe = 1'b1;
	assign o_request_to_send_b = st.rts_b;
	assign o_request_to_send_oe = 1'b1;
	assign o_rx_end_of_frame_irq = st.eof_pin;
	assign o_rx_end_of_frame_irq_oe = st.eof_oe;
	assign o_rx_irq_or_data_avail = st.rx_pin;
	assign o_rx_irq_or_data_avail_oe = st.rx_oe;
	assign o_data = st.dout;
	assign o_data_oe = st.dout_oe;
endmodule

//--- sim/hsl_link_properties.sv
// Checker for the serial link pins and receive signalling block
`timescale 1ns/1ps
module hsl_link_properties
	import hsl_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_level_one_control_bit,
	input wire logic i_serial_invert_bit,
	input wire logic i_end_of_frame_enable_bit,
	input wire logic i_end_of_frame_polarity_bit,
	input wire logic i_dma_irq_polarity_bit,
	input wire logic i_dma_select_bit,
	input wire logic i_rx_irq_dma_disable_bit,
	input wire logic [2:0] i_rx_fill_level,
	input wire logic i_tx_data_request,
	input wire logic i_tx_serial_clock,
	input wire logic i_dma_acknowledge,
	input wire logic o_tx_data,
	input wire logic o_request_to_send_b,
	input wire logic o_rx_end_of_frame_irq,
	input wire logic o_rx_end_of_frame_irq_oe,
	input wire logic o_rx_irq_or_data_avail,
	input wire logic o_data_oe,
	input wire logic [2:0] o_rx_count
);
	// Receive pin inactive, and interrupt mode unblocked
	logic rx_off;
	logic rx_ok;
	assign rx_off = o_rx_irq_or_data_avail != i_dma_irq_polarity_bit;
	assign rx_ok = !i_dma_select_bit && !i_rx_irq_dma_disable_bit && !i_tx_data_request;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	AST_RTS_IDLE: assert property (!i_level_one_control_bit [*3] |-> o_request_to_send_b)
		else $error("request to send active without handshake");
	// Pins show their released reset level at the first edge after release, so reset is sampled too
	AST_DAV_EXCL: assert property ((i_rst_b && i_dma_select_bit && i_tx_data_request
		&& $stable(i_dma_irq_polarity_bit)) [*2] |-> rx_off)
		else $error("data available with transmit request");
	AST_IRQ_ON: assert property ((i_rst_b && rx_ok && o_rx_count >= i_rx_fill_level
		&& $stable(i_dma_irq_polarity_bit)) [*2] |-> !rx_off)
		else $error("receive interrupt missing at fill level");
	AST_IRQ_OFF: assert property ((i_rst_b && !i_dma_select_bit && o_rx_count < i_rx_fill_level
		&& $stable(i_dma_irq_polarity_bit)) [*2] |-> rx_off)
		else $error("receive interrupt below fill level");
	AST_DAV_EMPTY: assert property ((i_rst_b && i_dma_select_bit && o_rx_count == HSL_Q_ZERO
		&& $stable(i_dma_irq_polarity_bit)) [*2] |-> rx_off)
		else $error("data available with empty queue");
	AST_ACK_BYTE: assert property ($rose(i_dma_acknowledge) && i_dma_select_bit && !rx_off
		|-> ##[1:3] o_data_oe)
		else $error("acknowledge did not drive a byte");
	AST_EOF_GATE: assert property ((i_rst_b && !i_end_of_frame_enable_bit
		&& $stable(i_end_of_frame_polarity_bit)) [*2] |-> o_rx_end_of_frame_irq != i_end_of_frame_polarity_bit)
		else $error("end of frame active while disabled");
	AST_EOF_OD: assert property (o_rx_end_of_frame_irq_oe == !o_rx_end_of_frame_irq)
		else $error("end of frame pin not open drain");
	AST_TX_EDGE: assert property ($changed(o_tx_data) && $stable(i_serial_invert_bit)
		|-> !$past(i_tx_serial_clock, 2))
		else $error("transmit bit changed off the falling edge");
	// Main scenarios reached
	COV_POP: cover property ($rose(i_dma_acknowledge) && !rx_off);
	COV_TX: cover property ($changed(o_tx_data));
	COV_EOF: cover property (o_rx_end_of_frame_irq == i_end_of_frame_polarity_bit);
endmodule
bind hsl_link hsl_link_properties u_props (
	.i_mclk(i_mclk),
	.i_rst_b(i_rst_b),
	.i_level_one_control_bit(i_level_one_control_bit),
	.i_serial_invert_bit(i_serial_invert_bit),
	.i_end_of_frame_enable_bit(i_end_of_frame_enable_bit),
	.i_end_of_frame_polarity_bit(i_end_of_frame_polarity_bit),
	.i_dma_irq_polarity_bit(i_dma_irq_polarity_bit),
	.i_dma_select_bit(i_dma_select_bit),
	.i_rx_irq_dma_disable_bit(i_rx_irq_dma_disable_bit),
	.i_rx_fill_level(i_rx_fill_level),
	.i_tx_data_request(i_tx_data_request),
	.i_tx_serial_clock(i_tx_serial_clock),
	.i_dma_acknowledge(i_dma_acknowledge),
	.o_tx_data(o_tx_data),
	.o_request_to_send_b(o_request_to_send_b),
	.o_rx_end_of_frame_irq(o_rx_end_of_frame_irq),
	.o_rx_end_of_frame_irq_oe(o_rx_end_of_frame_irq_oe),
	.o_rx_irq_or_data_avail(o_rx_irq_or_data_avail),
	.o_data_oe(o_data_oe),
	.o_rx_count(o_rx_count)
);

//--- sim/hsl_far_end.sv
// Far-end link controller model: serial clocks, receive data, clear to send
`timescale 1ns/1ps
module hsl_far_end (
	output logic o_rclk,
	output logic o_rxd,
	output logic o_tx_serial_clock,
	output logic o_cts_b,
	input wire logic i_txd,
	input wire logic i_rts_b
);
	// Half of a 125 ns link clock period
	localparam realtime HALF = 62.5;
	initial begin
		o_rclk = 1'b0;
		o_rxd = 1'b1;
		o_tx_serial_clock = 1'b1;
		o_cts_b = 1'b1;
	end
	always @(i_rts_b) o_cts_b <= #HALF i_rts_b;
	// Bit 0 first, stable at rise
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			o_rxd = b[i];
			#HALF o_rclk = 1'b1;
			#HALF o_rclk = 1'b0;
		end
		o_rxd = ~o_rxd;
	endtask
	// Clock runs only for the octet
	task automatic take_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			#HALF o_tx_serial_clock = 1'b0;
			#HALF o_tx_serial_clock = 1'b1;
			b[i] = i_txd;
		end
	endtask
endmodule

//--- sim/test_hsl_link.sv
// Self-checking bench for the serial link block
`timescale 1ns/1ps
module test_hsl_link
	import hsl_pkg::*;
;
	logic i_mclk, i_rst_b, level_one_control_bit, serial_invert_bit, eof_en, eof_pol, dpol, dsel, dis, txreq, txv, dreq, ack;
	logic [2:0] fill;
	logic [7:0] txo, got;
	wire rclk, rxd, tx_serial_clock, cts_b, txd, rts_b, eofi, davi, doe, trdy, txoe, rtsoe, eofoe, davoe;
	wire [7:0] dout;
	wire [2:0] cnt;
	int mismatches = 0;
	int comparisons = 0;
	hsl_far_end far (.o_rclk(rclk), .o_rxd(rxd), .o_tx_serial_clock(tx_serial_clock), .o_cts_b(cts_b), .i_txd(txd), .i_rts_b(rts_b));
	hsl_link dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_level_one_control_bit(level_one_control_bit), .i_serial_invert_bit(serial_invert_bit),
		.i_end_of_frame_enable_bit(eof_en), .i_end_of_frame_polarity_bit(eof_pol), .i_dma_irq_polarity_bit(dpol),
		.i_dma_select_bit(dsel), .i_rx_irq_dma_disable_bit(dis), .i_rx_fill_level(fill), .i_tx_request_bit(txreq),
		.i_tx_octet(txo), .i_tx_octet_valid(txv), .o_tx_octet_ready(trdy), .i_tx_data_request(dreq),
		.i_tx_serial_clock(tx_serial_clock), .i_rx_serial_clock(rclk), .i_rx_data(rxd), .i_clear_to_send_b(cts_b),
		.o_tx_data(txd), .o_tx_data_oe(txoe), .o_request_to_send_b(rts_b), .o_request_to_send_oe(rtsoe),
		.o_rx_end_of_frame_irq(eofi), .o_rx_end_of_frame_irq_oe(eofoe), .o_rx_irq_or_data_avail(davi),
		.o_rx_irq_or_data_avail_oe(davoe), .i_dma_acknowledge(ack), .o_data(dout), .o_data_oe(doe), .o_rx_count(cnt));
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic settle();
		repeat (10) @(posedge i_mclk);
	endtask
	task automatic pop(input logic [7:0] exp);
		@(posedge i_mclk) ack <= 1'b1;
		repeat (3) @(posedge i_mclk);
		chk("popped byte", exp, dout);
		chk("data drive", 8'h01, {7'h00, doe});
		@(posedge i_mclk) ack <= 1'b0;
		repeat (2) @(posedge i_mclk);
	endtask
	task automatic t_rx();
		far.send_byte(HSL_FLAG);
		far.send_byte(8'hA5);
		settle();
		chk("irq below level", 8'h00, {7'h00, davi});
		far.send_byte(8'h3C);
		settle();
		chk("queue count", 8'h02, {5'h00, cnt});
		chk("irq at level", 8'h01, {7'h00, davi});
		far.send_byte(HSL_FLAG);
		settle();
		chk("eof active low", 8'h00, {7'h00, eofi});
		chk("eof drive", 8'h01, {7'h00, eofoe});
		@(posedge i_mclk) eof_pol <= 1'b1;
		settle();
		chk("eof active high", 8'h01, {7'h00, eofi});
		@(posedge i_mclk) eof_en <= 1'b0;
		eof_pol <= 1'b0;
		dis <= 1'b1;
		settle();
		chk("eof disabled", 8'h01, {7'h00, eofi});
		chk("irq disabled", 8'h00, {7'h00, davi});
		$display("test rx done");
	endtask
	task automatic t_dma();
		@(posedge i_mclk) dsel <= 1'b1;
		dis <= 1'b0;
		dpol <= 1'b0;
		settle();
		chk("dav active low", 8'h00, {7'h00, davi});
		chk("dav drive", 8'h01, {7'h00, davoe});
		@(posedge i_mclk) dreq <= 1'b1;
		settle();
		chk("dav under request", 8'h01, {7'h00, davi});
		@(posedge i_mclk) dreq <= 1'b0;
		settle();
		pop(8'hA5);
		pop(8'h3C);
		chk("dav empty", 8'h01, {7'h00, davi});
		$display("test dma done");
	endtask
	task automatic t_inv();
		@(posedge i_mclk) serial_invert_bit <= 1'b1;
		fill <= 3'h1;
		far.send_byte(~8'h96);
		settle();
		chk("dav at level", 8'h00, {7'h00, davi});
		pop(8'h96);
		@(posedge i_mclk) serial_invert_bit <= 1'b0;
		for (int i = 1; i < 10; i++) far.send_byte(8'(i));
		settle();
		chk("full queue", {5'h00, HSL_Q_DEPTH}, {5'h00, cnt});
		for (int i = 1; i < 9; i++) pop(8'(i));
		chk("drained", 8'h00, {5'h00, cnt});
		$display("test invert and fill done");
	endtask
	task automatic t_tx();
		@(posedge i_mclk) level_one_control_bit <= 1'b1;
		txreq <= 1'b1;
		settle();
		chk("request to send", 8'h00, {7'h00, rts_b});
		chk("rts drive", 8'h01, {7'h00, rtsoe});
		chk("txd drive", 8'h01, {7'h00, txoe});
		@(posedge i_mclk) txv <= 1'b1;
		txo <= 8'h4B;
		for (int n = 0; n < 50 && trdy !== 1'b1; n++) @(posedge i_mclk);
		@(posedge i_mclk) txv <= 1'b0;
		#200;
		chk("octet busy", 8'h00, {7'h00, trdy});
		far.take_byte(got);
		chk("sent octet", 8'h4B, got);
		chk("octet done", 8'h01, {7'h00, trdy});
		$display("test tx done");
	endtask
	initial begin
		{level_one_control_bit, serial_invert_bit, eof_pol, dsel, dis, txreq, txv, dreq, ack, i_rst_b} = '0;
		{eof_en, dpol} = 2'h3;
		fill = 3'h2;
		txo = HSL_BYTE_ZERO;
		repeat (10) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		settle();
		chk("idle tx", 8'h01, {7'h00, txd});
		t_rx();
		t_dma();
		t_inv();
		t_tx();
		close_out();
	end
	initial begin
		#400us;
		mismatches++;
		close_out();
	end
endmodule
